// *** include/smcd_pkg.sv ***
/*
  Constants for the stepper motion command decoder: bit positions of the two
  command words, field widths and reset values.
  Assumes a single 50 MHz clock and a synchronous active-high reset.
*/
// Overview of operation
// - a command starts only on a 0-to-1 change of its bit, never when held
// - bit 14 edge loads the encoder counter with the signed target position
// - bit 13 edge launches the stored multi-segment sequence
// - option bit 9 picks blended (0) or dwell (1) sequence, dwell from word 9
// - option bit 4 sets blended sequence direction, 0 clockwise, 1 counter-clockwise
// - bit 10 edge clears command errors and move-done, not config error or lost
// - bit 9 edge loads motor position from target or scaled encoder per option 13
// - any motor position load clears position-lost, and move-done unless a move ends in that cycle
// - bit 8 edge starts continuous ccw run, bit 7 edge starts it cw
// - option bit 7 makes a continuous run a registration run
// - bit 6 edge starts origin search ccw first, bit 5 cw first
// - bit 4 edge halts at once; position lost only if moving or paused
// - bit 2 edge pauses the active move, ramping down then stopping
// - bit 3 edge continues a paused move to completion
// - starting another move while paused discards the paused move
// - bit 1 edge starts an offset move from current parameters
// - bit 0 edge starts a target move from current parameters
// - option bit 15 enables motor current, refused under configuration error
// - with network proximity in use, home input counts only while option bit 11 is 1
// - option bit 8 defers a move commanded while idle or pending until an indexed-start input rising edge
package smcd_pkg;
  localparam int W_WORD = 16;
  localparam int W_POS  = 32;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_POS  = 32'h0000_0000;
  // trigger word bit positions
  localparam int B_TARGET   = 0;
  localparam int B_OFFSET   = 1;
  localparam int B_PAUSE    = 2;
  localparam int B_CONTINUE = 3;
  localparam int B_HALT     = 4;
  localparam int B_ORG_CW   = 5;
  localparam int B_ORG_CCW  = 6;
  localparam int B_RUN_CW   = 7;
  localparam int B_RUN_CCW  = 8;
  localparam int B_LOAD_POS = 9;
  localparam int B_CLEAR    = 10;
  localparam int B_SEQ      = 13;
  localparam int B_LOAD_ENC = 14;
  localparam int B_MODE     = 15;
  // option word bit positions
  localparam int O_REVERSE  = 4;
  localparam int O_REGISTER = 7;
  localparam int O_INDEXED  = 8;
  localparam int O_DWELL    = 9;
  localparam int O_PROX     = 11;
  localparam int O_SOURCE   = 13;
  localparam int O_ENABLE   = 15;
  localparam logic [15:0] OPT_RESERVED = 16'h5440;
  // trigger bits that start a move
  localparam logic [15:0] MOVE_MASK = 16'h21e3;
  // run_cnt value that ends a move without motion_done_i, after RUN_CYCLES+1 cycles; stands in for the profile generator's end
  localparam int RUN_CYCLES = 64;
  typedef enum logic [1:0] {
    SMCD_IDLE    = 2'b00,
    SMCD_PENDING = 2'b01,
    SMCD_MOVING  = 2'b10,
    SMCD_PAUSED  = 2'b11
  } smcd_state_t;
endpackage : smcd_pkg

// *** hdl/smcd_edge.sv ***
/*
  Per-bit rising edge detector across process-data updates.
  Assumes update_i is a one-cycle pulse in the sys_clk_i domain.
*/
`timescale 1ns/10ps
`default_nettype none
module smcd_edge
  import smcd_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             update_i,
  input  wire logic [WIDTH-1:0] word_i,
  output logic      [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] prev;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prev <= '0;
    end else if (update_i) begin
      prev <= word_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // one pulse per update only, so a held bit cannot retrigger
      assign rise_o[g] = update_i & word_i[g] & ~prev[g];
    end
  endgenerate
endmodule : smcd_edge
`default_nettype wire

// *** hdl/smcd_top.sv ***
/*
  Stepper motion command decoder: decodes the trigger and option words of each
  process-data update into one-cycle action strobes and status flags.
  Assumes update_i marks a fresh pair of words from the fieldbus logic on the
  same clock; home and indexed-start pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module smcd_top
  import smcd_pkg::*;
#(
  parameter int RUN_LEN = RUN_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        update_i,
  input  wire logic [15:0] trigger_word_i,
  input  wire logic [15:0] option_word_i,
  input  wire logic [31:0] target_position_i,
  input  wire logic [31:0] encoder_scaled_i,
  input  wire logic [15:0] dwell_ms_i,
  input  wire logic        config_error_i,
  input  wire logic        prox_in_use_i,
  input  wire logic        home_pin_i,
  input  wire logic        index_pin_i,
  input  wire logic        motion_done_i,
  output logic             target_motion_o,
  output logic             offset_motion_o,
  output logic             motion_pause_o,
  output logic             paused_motion_continue_o,
  output logic             halt_o,
  output logic             origin_search_cw_o,
  output logic             origin_search_ccw_o,
  output logic             continuous_run_cw_o,
  output logic             continuous_run_ccw_o,
  output logic             registration_o,
  output logic             stored_sequence_launch_o,
  output logic             sequence_dwell_o,
  output logic             sequence_reverse_o,
  output logic [15:0]      dwell_ms_o,
  output logic             discard_paused_o,
  output logic             fault_clear_o,
  output logic [31:0]      encoder_count_o,
  output logic [31:0]      motor_position_o,
  output logic             motor_current_en_o,
  output logic             home_event_o,
  output logic             command_error_o,
  output logic             move_done_o,
  output logic             position_lost_o,
  output logic [1:0]       motion_state_o
);
  logic [15:0]  rise;
  logic         opt_bad;
  logic         multi;
  logic         accept;
  logic [15:0]  act;
  logic [15:0]  held_act;
  logic [15:0]  held_opt;
  logic [15:0]  next_act;
  logic [15:0]  next_opt;
  logic         start_go;
  logic         moving;
  logic [2:0]   home_sync;
  logic [2:0]   index_sync;
  logic         home_lvl;
  logic         index_lvl;
  logic         index_rise;
  smcd_state_t  state;
  logic [$clog2(RUN_LEN+1)-1:0] run_cnt;

  smcd_edge #(
    .WIDTH(W_WORD)
  ) u_edge (
    .sys_clk_i(sys_clk_i),
    .srst_i   (srst_i),
    .update_i (update_i),
    .word_i   (trigger_word_i),
    .rise_o   (rise)
  );

  // the master keeps bit 15 low; a high bit means configuration data, not ours
  assign opt_bad = |(option_word_i & OPT_RESERVED);
  // more than one edge per update is refused rather than guessed at
  assign multi   = (rise & (rise - 16'h0001)) != 16'h0000;
  assign accept  = update_i & ~trigger_word_i[B_MODE] & ~opt_bad & ~multi;
  assign act     = accept ? rise : 16'h0000;

  // pin synchronisers: change counts once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      home_sync  <= 3'b000;
      index_sync <= 3'b000;
      home_lvl   <= 1'b0;
      index_lvl  <= 1'b0;
    end else begin
      home_sync  <= {home_sync[1:0], home_pin_i};
      index_sync <= {index_sync[1:0], index_pin_i};
      if (home_sync[1] == home_sync[2]) begin
        home_lvl <= home_sync[2];
      end
      if (index_sync[1] == index_sync[2]) begin
        index_lvl <= index_sync[2];
      end
    end
  end

  logic home_q;
  logic index_q;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      home_q  <= 1'b0;
      index_q <= 1'b0;
    end else begin
      home_q  <= home_lvl;
      index_q <= index_lvl;
    end
  end
  assign index_rise = index_lvl & ~index_q;

  // home rising edges pass unless network proximity is in use and the proximity bit is low
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      home_event_o <= 1'b0;
    end else begin
      home_event_o <= (home_lvl & ~home_q) &
                      (~prox_in_use_i | option_word_i[O_PROX]);
    end
  end

  // a move with the indexed bit, commanded while idle or pending, waits for the indexed-start pin
  always_comb begin
    next_act = act;
    next_opt = option_word_i;
    start_go = 1'b0;
    if ((act & MOVE_MASK) != 16'h0000 && option_word_i[O_INDEXED]) begin
      next_act = 16'h0000;
    end else if (state == SMCD_PENDING && index_rise) begin
      next_act = held_act;
      next_opt = held_opt;
      start_go = 1'b1;
    end else if ((act & MOVE_MASK) != 16'h0000) begin
      start_go = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      held_act <= RST_WORD;
      held_opt <= RST_WORD;
    end else if ((act & MOVE_MASK) != 16'h0000 && option_word_i[O_INDEXED]) begin
      held_act <= act;
      held_opt <= option_word_i;
    end
  end

  // action strobes, one cycle each
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      target_motion_o          <= 1'b0;
      offset_motion_o          <= 1'b0;
      motion_pause_o           <= 1'b0;
      paused_motion_continue_o <= 1'b0;
      halt_o                   <= 1'b0;
      origin_search_cw_o       <= 1'b0;
      origin_search_ccw_o      <= 1'b0;
      continuous_run_cw_o      <= 1'b0;
      continuous_run_ccw_o     <= 1'b0;
      stored_sequence_launch_o <= 1'b0;
      fault_clear_o            <= 1'b0;
      discard_paused_o         <= 1'b0;
    end else begin
      target_motion_o          <= next_act[B_TARGET];
      offset_motion_o          <= next_act[B_OFFSET];
      motion_pause_o           <= act[B_PAUSE] & moving;
      paused_motion_continue_o <= act[B_CONTINUE] & (state == SMCD_PAUSED);
      halt_o                   <= act[B_HALT];
      origin_search_cw_o       <= next_act[B_ORG_CW];
      origin_search_ccw_o      <= next_act[B_ORG_CCW];
      continuous_run_cw_o      <= next_act[B_RUN_CW];
      continuous_run_ccw_o     <= next_act[B_RUN_CCW];
      stored_sequence_launch_o <= next_act[B_SEQ];
      fault_clear_o            <= act[B_CLEAR];
      discard_paused_o         <= start_go & (state == SMCD_PAUSED);
    end
  end

  // move qualifiers, latched with the move so they stay valid while it runs
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      registration_o     <= 1'b0;
      sequence_dwell_o   <= 1'b0;
      sequence_reverse_o <= 1'b0;
      dwell_ms_o         <= RST_WORD;
    end else if (start_go) begin
      // registration only qualifies a continuous run, other moves leave it low
      registration_o     <= next_opt[O_REGISTER] &
                            (next_act[B_RUN_CW] | next_act[B_RUN_CCW]);
      sequence_dwell_o   <= next_opt[O_DWELL];
      sequence_reverse_o <= next_opt[O_REVERSE] & ~next_opt[O_DWELL];
      dwell_ms_o         <= dwell_ms_i;
    end
  end

  // position loads
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      encoder_count_o  <= RST_POS;
      motor_position_o <= RST_POS;
    end else begin
      if (act[B_LOAD_ENC]) begin
        encoder_count_o <= target_position_i;
      end
      if (act[B_LOAD_POS]) begin
        motor_position_o <= option_word_i[O_SOURCE] ? encoder_scaled_i
                                                    : target_position_i;
      end
    end
  end

  // driver current follows the option bit, blocked by a configuration error
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      motor_current_en_o <= 1'b0;
    end else if (update_i) begin
      motor_current_en_o <= option_word_i[O_ENABLE] & ~config_error_i;
    end else if (config_error_i) begin
      motor_current_en_o <= 1'b0;
    end
  end

  // motion tracking: moving ends on motion_done_i or after RUN_LEN+1 cycles, once run_cnt reaches RUN_LEN
  assign moving = (state == SMCD_MOVING);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state   <= SMCD_IDLE;
      run_cnt <= '0;
    end else begin
      unique case (state)
        SMCD_IDLE: begin
          if (start_go) begin
            state   <= SMCD_MOVING;
            run_cnt <= '0;
          end else if ((act & MOVE_MASK) != 16'h0000) begin
            state <= SMCD_PENDING;
          end
        end
        SMCD_PENDING: begin
          if (act[B_HALT]) begin
            state <= SMCD_IDLE;
          end else if (start_go) begin
            state   <= SMCD_MOVING;
            run_cnt <= '0;
          end
        end
        SMCD_MOVING: begin
          if (act[B_HALT]) begin
            state <= SMCD_IDLE;
          end else if (act[B_PAUSE]) begin
            state <= SMCD_PAUSED;
          end else if (start_go) begin
            run_cnt <= '0;
          end else if (motion_done_i || run_cnt == RUN_LEN[$bits(run_cnt)-1:0]) begin
            state <= SMCD_IDLE;
          end else begin
            run_cnt <= run_cnt + 1'b1;
          end
        end
        SMCD_PAUSED: begin
          if (act[B_HALT]) begin
            state <= SMCD_IDLE;
          end else if (start_go || act[B_CONTINUE]) begin
            state   <= SMCD_MOVING;
            run_cnt <= '0;
          end
        end
      endcase
      if (state == SMCD_IDLE && (act & MOVE_MASK) != 16'h0000 && !start_go) begin
        state <= SMCD_PENDING;
      end
    end
  end
  assign motion_state_o = state;

  // status flags; set wins over clear
  logic done_set;
  assign done_set = moving & (motion_done_i | run_cnt == RUN_LEN[$bits(run_cnt)-1:0]);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      move_done_o     <= 1'b0;
      position_lost_o <= 1'b0;
      command_error_o <= 1'b0;
    end else begin
      if (done_set) begin
        move_done_o <= 1'b1;
      end else if (act[B_CLEAR] || act[B_LOAD_POS]) begin
        move_done_o <= 1'b0;
      end
      if (act[B_HALT] && state != SMCD_IDLE && state != SMCD_PENDING) begin
        position_lost_o <= 1'b1;
      end else if (act[B_LOAD_POS]) begin
        position_lost_o <= 1'b0;
      end
      if (update_i && rise != 16'h0000 && (opt_bad || multi)) begin
        command_error_o <= 1'b1;
      end else if (act[B_CLEAR]) begin
        command_error_o <= 1'b0;
      end
    end
  end

  a_edge_once: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    halt_o |=> !halt_o) else $error("halt strobe longer than one cycle");
  a_enc_load: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    act[B_LOAD_ENC] |=> encoder_count_o == $past(target_position_i))
    else $error("encoder count not loaded");
  a_pos_src: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    act[B_LOAD_POS] && option_word_i[O_SOURCE] |=> motor_position_o == $past(encoder_scaled_i))
    else $error("motor position not taken from encoder");
  a_pos_flags: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    act[B_LOAD_POS] && !done_set |=> !move_done_o && !position_lost_o)
    else $error("flags not cleared by position load");
  a_halt_lost: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    act[B_HALT] && state == SMCD_IDLE && !position_lost_o |=> !position_lost_o)
    else $error("position lost set while idle");
  a_cur_block: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    config_error_i |=> !motor_current_en_o) else $error("current enabled under error");
  a_resv_err: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    update_i && opt_bad && rise != 16'h0000 |=> command_error_o && !target_motion_o)
    else $error("reserved bit update executed");
  a_index_wait: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    act[B_TARGET] && option_word_i[O_INDEXED] |=> !target_motion_o)
    else $error("indexed move started early");
  a_pause_go: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state == SMCD_MOVING && act[B_PAUSE] && !act[B_HALT] |=> motion_pause_o ##0 state == SMCD_PAUSED)
    else $error("pause not taken");
endmodule : smcd_top
`default_nettype wire

// *** test/smcd_master_model.sv ***
/*
  Fieldbus master model: turns bench requests into process-data updates.
  Assumes the bench raises req_i for one cycle per update; bad_i lets a scenario
  send words that a careful master never would.
*/
`timescale 1ns/10ps
`default_nettype none
module smcd_master_model
  import smcd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        req_i,
  input  wire logic        bad_i,
  input  wire logic [15:0] trig_i,
  input  wire logic [15:0] opt_i,
  output logic             update_o,
  output logic [15:0]      trigger_word_o,
  output logic [15:0]      option_word_o
);
  logic [15:0] rising;
  logic [15:0] clean;
  // a careful master lets only the lowest new bit rise in one update
  assign rising = trig_i & ~trigger_word_o;
  assign clean  = (trig_i & trigger_word_o) | (rising & (~rising + 16'h0001));
  always_ff @(posedge sys_clk_i) begin
    update_o <= req_i && !srst_i;
  end
  // words only move on a request, so a pending indexed move sees them held
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      trigger_word_o <= 16'h0000;
      option_word_o  <= 16'h0000;
    end else if (req_i) begin
      trigger_word_o <= bad_i ? trig_i : {1'b0, clean[14:0]};
      option_word_o  <= bad_i ? opt_i : (opt_i & ~OPT_RESERVED);
    end
  end
endmodule : smcd_master_model
`default_nettype wire

// *** test/smcd_top_tb_top.sv ***
/*
  Self-checking bench for the motion command decoder.
  Assumes the master model turns each request into one update one edge later.
*/
`timescale 1ns/10ps
`default_nettype none
module smcd_top_tb_top;
  localparam int RUN = 60;
  logic        sys_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        req = 1'b0, bad = 1'b0;
  logic [15:0] trig = 16'h0000, opt = 16'h0000, dwell_ms_i = 16'h0000;
  logic [31:0] target_position_i = 32'h0000_0000, encoder_scaled_i = 32'h0000_0000;
  logic        config_error_i = 1'b0, prox_in_use_i = 1'b0, home_pin_i = 1'b0;
  logic        index_pin_i = 1'b0, motion_done_i = 1'b0, update_i;
  logic [15:0] trigger_word_i, option_word_i, dwell_ms_o, strobes;
  logic        target_motion_o, offset_motion_o, motion_pause_o, paused_motion_continue_o;
  logic        halt_o, origin_search_cw_o, origin_search_ccw_o, continuous_run_cw_o;
  logic        continuous_run_ccw_o, registration_o, stored_sequence_launch_o;
  logic        sequence_dwell_o, sequence_reverse_o, discard_paused_o, fault_clear_o;
  logic        motor_current_en_o, home_event_o, command_error_o, move_done_o;
  logic        position_lost_o;
  logic [31:0] encoder_count_o, motor_position_o;
  logic [1:0]  motion_state_o;
  int          bad_count = 0, comparisons = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  smcd_master_model i_smcd_master_model (.sys_clk_i, .srst_i, .req_i(req), .bad_i(bad),
    .trig_i(trig), .opt_i(opt), .update_o(update_i), .trigger_word_o(trigger_word_i),
    .option_word_o(option_word_i));
  smcd_top #(.RUN_LEN(RUN)) i_smcd_top (.sys_clk_i, .srst_i, .update_i, .trigger_word_i,
    .option_word_i, .target_position_i, .encoder_scaled_i, .dwell_ms_i, .config_error_i,
    .prox_in_use_i, .home_pin_i, .index_pin_i, .motion_done_i, .target_motion_o,
    .offset_motion_o, .motion_pause_o, .paused_motion_continue_o, .halt_o,
    .origin_search_cw_o, .origin_search_ccw_o, .continuous_run_cw_o, .continuous_run_ccw_o,
    .registration_o, .stored_sequence_launch_o, .sequence_dwell_o, .sequence_reverse_o,
    .dwell_ms_o, .discard_paused_o, .fault_clear_o, .encoder_count_o, .motor_position_o,
    .motor_current_en_o, .home_event_o, .command_error_o, .move_done_o, .position_lost_o,
    .motion_state_o);

  // strobes sit at the trigger bit that launches them; 11 and 12 hold the rest
  assign strobes = {2'b00, stored_sequence_launch_o, discard_paused_o, home_event_o,
    fault_clear_o, 1'b0, continuous_run_ccw_o, continuous_run_cw_o, origin_search_ccw_o,
    origin_search_cw_o, halt_o, paused_motion_continue_o, motion_pause_o, offset_motion_o,
    target_motion_o};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // fixed window: every strobe must land inside it, so nothing waits open-ended
  task automatic watch(input int n, output logic [15:0] seen);
    seen = 16'h0000;
    repeat (n) begin
      @(posedge sys_clk_i);
      seen = seen | strobes;
    end
  endtask : watch

  task automatic send(input logic [15:0] t, input logic [15:0] o, input logic b,
                      output logic [15:0] seen);
    req <= 1'b1;
    trig <= t;
    opt <= o;
    bad <= b;
    @(posedge sys_clk_i);
    req <= 1'b0;
    watch(5, seen);
  endtask : send

  task automatic finish_move();
    logic [15:0] s;
    motion_done_i <= 1'b1;
    @(posedge sys_clk_i);
    motion_done_i <= 1'b0;
    watch(3, s);
  endtask : finish_move

  task automatic sc_commands();
    logic [15:0] s;
    int bits[9] = '{0, 1, 4, 5, 6, 7, 8, 10, 13};
    foreach (bits[i]) begin
      send(16'h0000, 16'h0000, 1'b0, s);
      send(16'h0001 << bits[i], 16'h0000, 1'b0, s);
      check(s, 16'h0001 << bits[i]);
      send(16'h0001 << bits[i], 16'h0000, 1'b0, s);
      check(s, 16'h0000);
      if (bits[i] == 4) check(position_lost_o, 1'b0);
      if (bits[i] == 10) check(move_done_o, 1'b0);
      finish_move();
    end
  endtask : sc_commands

  task automatic sc_pause();
    logic [15:0] s;
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0001, 16'h0000, 1'b0, s);
    check(motion_state_o, 2'd2);
    send(16'h0005, 16'h0000, 1'b0, s);
    check({s, 14'h0000, motion_state_o}, {16'h0004, 16'h0003});
    send(16'h000d, 16'h0000, 1'b0, s);
    check({s, 14'h0000, motion_state_o}, {16'h0008, 16'h0002});
    send(16'h0009, 16'h0000, 1'b0, s);
    send(16'h000d, 16'h0000, 1'b0, s);
    send(16'h000f, 16'h0000, 1'b0, s);
    check(s, 16'h1002);
    finish_move();
  endtask : sc_pause

  task automatic sc_halt_errors();
    logic [15:0] s;
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0080, 16'h0000, 1'b0, s);
    send(16'h0090, 16'h0000, 1'b0, s);
    check({s, 15'h0000, position_lost_o}, {16'h0010, 16'h0001});
    send(16'h0000, 16'h0040, 1'b1, s);
    send(16'h0001, 16'h0040, 1'b1, s);
    check({s, 15'h0000, command_error_o}, {16'h0000, 16'h0001});
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0003, 16'h0000, 1'b1, s);
    check(s, 16'h0000);
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h8001, 16'h0000, 1'b1, s);
    check(s, 16'h0000);
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0400, 16'h0000, 1'b0, s);
    check({s, command_error_o, position_lost_o}, {16'h0400, 2'b01});
  endtask : sc_halt_errors

  task automatic sc_loads();
    logic [15:0] s;
    target_position_i <= 32'h8000_0123;
    encoder_scaled_i <= 32'h0001_2345;
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0001, 16'h0000, 1'b0, s);
    watch(RUN - 10, s);
    check(motion_state_o, 2'd2);
    watch(10, s);
    check({move_done_o, motion_state_o}, 3'b100);
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0200, 16'h0000, 1'b0, s);
    check(motor_position_o, 32'h8000_0123);
    check({move_done_o, position_lost_o}, 2'b00);
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0200, 16'h2000, 1'b0, s);
    check(motor_position_o, 32'h0001_2345);
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h4000, 16'h0000, 1'b0, s);
    check(encoder_count_o, 32'h8000_0123);
  endtask : sc_loads

  task automatic sc_options();
    logic [15:0] s;
    dwell_ms_i <= 16'h01f4;
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h2000, 16'h0200, 1'b0, s);
    check({sequence_dwell_o, dwell_ms_o}, {1'b1, 16'h01f4});
    finish_move();
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h2000, 16'h0010, 1'b0, s);
    check({sequence_dwell_o, sequence_reverse_o}, 2'b01);
    finish_move();
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0100, 16'h0080, 1'b0, s);
    check({s, 15'h0000, registration_o}, {16'h0100, 16'h0001});
    finish_move();
  endtask : sc_options

  task automatic sc_current();
    logic [15:0] s;
    send(16'h0000, 16'h8000, 1'b0, s);
    check(motor_current_en_o, 1'b1);
    config_error_i <= 1'b1;
    watch(2, s);
    check(motor_current_en_o, 1'b0);
    send(16'h0000, 16'h8000, 1'b0, s);
    check(motor_current_en_o, 1'b0);
    config_error_i <= 1'b0;
  endtask : sc_current

  task automatic sc_indexed_home();
    logic [15:0] s;
    send(16'h0000, 16'h0000, 1'b0, s);
    send(16'h0001, 16'h0100, 1'b0, s);
    check({s, 14'h0000, motion_state_o}, {16'h0000, 16'h0001});
    index_pin_i <= 1'b1;
    watch(12, s);
    check(s, 16'h0001);
    index_pin_i <= 1'b0;
    finish_move();
    prox_in_use_i <= 1'b1;
    send(16'h0000, 16'h0000, 1'b0, s);
    home_pin_i <= 1'b1;
    watch(12, s);
    check(s, 16'h0000);
    home_pin_i <= 1'b0;
    send(16'h0000, 16'h0800, 1'b0, s);
    home_pin_i <= 1'b1;
    watch(12, s);
    check(s, 16'h0800);
    home_pin_i <= 1'b0;
  endtask : sc_indexed_home

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    sc_commands();
    sc_pause();
    sc_halt_errors();
    sc_loads();
    sc_options();
    sc_current();
    sc_indexed_home();
    stop_test();
  end
endmodule : smcd_top_tb_top
`default_nettype wire
